// *** core/lpdm_pkg.sv ***
// Constants, command codes and sequencer states for the low power DDR pattern store controller.
package lpdm_pkg;

	localparam int SYS_CLK_MHZ    = 100;
	localparam int MEM_CLK_MHZ    = 166;
	localparam int DATA_BITS      = 16;
	localparam int BURST_LEN      = 4;
	localparam int BANK_BITS      = 2;
	localparam int ROW_BITS       = 12;
	localparam int COL_BITS       = 9;
	localparam int WORD_ADDR_BITS = ROW_BITS + BANK_BITS + COL_BITS;
	localparam int MEM_A_BITS     = 13;
	localparam int AP_BIT         = 10;
	localparam int LINE_BITS      = DATA_BITS * BURST_LEN;
	localparam int MASK_BITS      = 2 * BURST_LEN;
	localparam int ROW_COUNT      = 4096;

	localparam int T_INIT_US      = 200;
	localparam int T_REFRESH_MS   = 64;
	localparam int T_RFC_NS       = 72;
	localparam int T_WR_NS        = 15;

	// Least times round up, longest times round down, never below one cycle.
	function automatic int cycles_ceil(input int ns);
		int c;
		c = (ns * MEM_CLK_MHZ + 999) / 1000;
		return (c < 1) ? 1 : c;
	endfunction

	function automatic int cycles_floor(input int ns);
		int c;
		c = (ns * MEM_CLK_MHZ) / 1000;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int INIT_CYCLES      = T_INIT_US * MEM_CLK_MHZ;
	localparam int REF_INTERVAL_NS  = T_REFRESH_MS * 1000000 / ROW_COUNT;
	localparam int REF_CYCLES       = cycles_floor(REF_INTERVAL_NS);
	localparam int RFC_CYCLES       = cycles_ceil(T_RFC_NS);
	localparam int WR_CYCLES        = cycles_ceil(T_WR_NS);
	localparam int CAS_LATENCY      = 3;
	localparam int T_RCD_CYCLES     = 3;
	localparam int T_RP_CYCLES      = 3;
	localparam int T_MRD_CYCLES     = 2;
	localparam int INIT_REFRESHES   = 2;
	localparam int REF_SLACK_CYCLES = 32;
	localparam int WAIT_BITS        = 16;

	localparam logic [2:0] MODE_BL4 = 3'h2;
	localparam logic [2:0] MODE_CL3 = 3'h3;
	localparam logic [MEM_A_BITS-1:0] MODE_WORD = {6'h00, MODE_CL3, 1'b0, MODE_BL4};

	// Command order is {cs_n, ras_n, cas_n, we_n}.
	localparam logic [3:0] CMD_DESEL = 4'hf;
	localparam logic [3:0] CMD_NOP   = 4'h7;
	localparam logic [3:0] CMD_ACT   = 4'h3;
	localparam logic [3:0] CMD_READ  = 4'h5;
	localparam logic [3:0] CMD_WRITE = 4'h4;
	localparam logic [3:0] CMD_PRE   = 4'h2;
	localparam logic [3:0] CMD_REF   = 4'h1;
	localparam logic [3:0] CMD_MRS   = 4'h0;

	// Beat schedule in link clock cycles after the read or write command is launched.
	localparam logic [3:0] BEAT_DQS_ON   = 4'h1;
	localparam logic [3:0] BEAT_WR_FIRST = 4'h3;
	localparam logic [3:0] BEAT_WR_LAST  = 4'h6;
	localparam logic [3:0] BEAT_DQS_OFF  = 4'h7;
	localparam logic [3:0] BEAT_RD_FIRST = 4'(2 * CAS_LATENCY + 4);
	localparam logic [3:0] BEAT_RD_LAST  = 4'(2 * CAS_LATENCY + 7);
	localparam logic [3:0] BEAT_END      = 4'(2 * CAS_LATENCY + 8);

	typedef enum logic [3:0] {
		ST_INIT_WAIT = 4'h0,
		ST_INIT_PRE  = 4'h1,
		ST_INIT_REF  = 4'h2,
		ST_INIT_MRS  = 4'h3,
		ST_IDLE      = 4'h4,
		ST_RW        = 4'h5,
		ST_PRE       = 4'h6,
		ST_DONE      = 4'h7,
		ST_REF       = 4'h8
	} lpdm_state_type;

endpackage

// *** core/lpdm_sync.sv ***
// Two flip-flop synchroniser for levels and toggles entering a clock domain.
`timescale 1ns/100ps
module lpdm_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule

// *** core/lpdm_ctrl.sv ***
// Pattern store controller driving one x16 low power DDR memory from a doubled link clock.
//
// Notes on behaviour
// - Pattern bursts are written into and read back from the external memory.
// - Data path is sixteen bits wide; memory clock nominally 166 MHz.
// - Addressing covers 128 Mb only; row address upper bits stay low.
// - Four equal banks, selected by the bank address field.
// - Every access is a burst of four; mode register programmed to match.
// - Every row is refreshed within 64 ms.
// - CAS latency, activate-to-access and precharge each take three clocks.
// - Partial-array and temperature-compensated self-refresh are never programmed.
// - Memory clock leaves as a complementary differential pair.
// - Each byte lane has its own strobe and write mask.
`timescale 1ns/100ps
module lpdm_ctrl
	import lpdm_pkg::*;
#(
	parameter int INIT_WAIT_CYCLES = INIT_CYCLES
) (
	input  wire logic                      clk,
	input  wire logic                      reset,
	input  wire logic                      link_clk,
	input  wire logic                      req_valid,
	output logic                           req_ready,
	input  wire logic                      req_write,
	input  wire logic [WORD_ADDR_BITS-1:0] req_addr,
	input  wire logic [LINE_BITS-1:0]      req_wdata,
	input  wire logic [MASK_BITS-1:0]      req_wmask,
	output logic                           rsp_valid,
	output logic [LINE_BITS-1:0]           rsp_rdata,
	output logic                           init_done,
	output logic                           mem_clk_p,
	output logic                           mem_clk_n,
	output logic                           mem_cke,
	output logic                           mem_cs_n,
	output logic                           mem_ras_n,
	output logic                           mem_cas_n,
	output logic                           mem_we_n,
	output logic [MEM_A_BITS-1:0]          mem_addr,
	output logic [BANK_BITS-1:0]           mem_ba,
	input  wire logic [DATA_BITS-1:0]      mem_dq_in,
	output logic [DATA_BITS-1:0]           mem_dq_out,
	output logic                           mem_dq_oe_n,
	input  wire logic                      low_byte_strobe_in,
	output logic                           low_byte_strobe_out,
	output logic                           low_byte_strobe_oe_n,
	input  wire logic                      high_byte_strobe_in,
	output logic                           high_byte_strobe_out,
	output logic                           high_byte_strobe_oe_n,
	output logic                           low_byte_write_mask,
	output logic                           high_byte_write_mask
);
	function automatic logic [WAIT_BITS-1:0] wait_of(input int cycles);
		return WAIT_BITS'(cycles - 1);
	endfunction

	// System clock side: one request held stable until its answer returns.
	logic                      busy;
	logic                      req_tgl;
	logic                      ack_seen;
	logic                      hold_write;
	logic [WORD_ADDR_BITS-1:0] hold_addr;
	logic [LINE_BITS-1:0]      hold_wdata;
	logic [MASK_BITS-1:0]      hold_wmask;
	logic                      ack_s;
	logic                      init_s;
	logic                      ack_tgl;
	logic                      init_flag;
	logic [DATA_BITS-1:0]      rd_buf [0:BURST_LEN-1];

	wire take       = req_valid & req_ready;
	wire ack_new    = ack_s ^ ack_seen;
	wire next_busy  = take | (busy & ~ack_new);

	lpdm_sync #(.WIDTH(2)) u_to_sys (
		.clk   (clk),
		.reset (reset),
		.d     ({ack_tgl, init_flag}),
		.q     ({ack_s, init_s})
	);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			busy       <= 1'b0;
			req_tgl    <= 1'b0;
			ack_seen   <= 1'b0;
			req_ready  <= 1'b0;
			rsp_valid  <= 1'b0;
			rsp_rdata  <= '0;
			init_done  <= 1'b0;
			hold_write <= 1'b0;
			hold_addr  <= '0;
			hold_wdata <= '0;
			hold_wmask <= '0;
		end else begin
			busy      <= next_busy;
			req_ready <= ~next_busy & init_s;
			rsp_valid <= ack_new;
			init_done <= init_s;
			if (ack_new) begin
				ack_seen  <= ack_s;
				rsp_rdata <= {rd_buf[3], rd_buf[2], rd_buf[1], rd_buf[0]};
			end
			if (take) begin
				req_tgl    <= ~req_tgl;
				hold_write <= req_write;
				hold_addr  <= req_addr;
				hold_wdata <= req_wdata;
				hold_wmask <= req_wmask;
			end
		end
	end

	// Link side: the memory clock is the link clock halved, so each half period is one beat.
	lpdm_state_type            state;
	lpdm_state_type            next_state;
	logic [WAIT_BITS-1:0]      wait_cnt;
	logic [WAIT_BITS-1:0]      next_wait;
	logic [WAIT_BITS-1:0]      ref_timer;
	logic [1:0]                init_refs;
	logic [1:0]                next_refs;
	logic [3:0]                next_cmd;
	logic [MEM_A_BITS-1:0]     next_addr;
	logic [BANK_BITS-1:0]      next_ba;
	logic                      req_s;
	logic                      req_seen;
	logic                      ref_due;
	logic                      lk_write;
	logic [LINE_BITS-1:0]      lk_wdata;
	logic [MASK_BITS-1:0]      lk_wmask;
	logic [3:0]                beat_cnt;
	logic [DATA_BITS-1:0]      dq_s;

	wire       slot      = mem_clk_p;
	wire       req_new   = req_s ^ req_seen;
	wire       ref_hit   = slot & (ref_timer == '0);
	wire [ROW_BITS-1:0]  row  = hold_addr[WORD_ADDR_BITS-1 -: ROW_BITS];
	wire [BANK_BITS-1:0] bank = hold_addr[COL_BITS +: BANK_BITS];
	wire [COL_BITS-1:0]  col  = {hold_addr[COL_BITS-1:2], 2'h0};
	wire       issue_act = slot & (wait_cnt == '0) & (state == ST_IDLE) & ~ref_due & req_new;
	wire       issue_rw  = slot & (wait_cnt == '0) & (state == ST_RW);
	wire       issue_ref = slot & (wait_cnt == '0) & (state == ST_REF);
	// The precharge wait must be over too, or a write would toggle the answer twice.
	wire       finish    = slot & (state == ST_DONE) & (wait_cnt == '0) & (beat_cnt == '0);
	wire [1:0] wr_idx    = 2'(beat_cnt - BEAT_WR_FIRST);
	wire [1:0] rd_idx    = 2'(beat_cnt - BEAT_RD_FIRST);
	wire       dqs_drive = lk_write & (beat_cnt >= BEAT_DQS_ON) & (beat_cnt < BEAT_DQS_OFF);
	wire       dq_drive  = lk_write & (beat_cnt >= BEAT_WR_FIRST) & (beat_cnt <= BEAT_WR_LAST);
	wire       rd_take   = ~lk_write & (beat_cnt >= BEAT_RD_FIRST) & (beat_cnt <= BEAT_RD_LAST);
	wire [3:0] out_cmd   = {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n};

	lpdm_sync #(.WIDTH(1)) u_req_sync (
		.clk   (link_clk),
		.reset (reset),
		.d     (req_tgl),
		.q     (req_s)
	);

	// Read data is taken at a fixed beat count; the strobe inputs are not used to capture.
	lpdm_sync #(.WIDTH(DATA_BITS)) u_dq_sync (
		.clk   (link_clk),
		.reset (reset),
		.d     (mem_dq_in),
		.q     (dq_s)
	);

	always_comb begin
		next_state = state;
		next_wait  = wait_cnt;
		next_refs  = init_refs;
		next_cmd   = CMD_NOP;
		next_addr  = mem_addr;
		next_ba    = mem_ba;
		if (wait_cnt != '0) begin
			next_wait = wait_cnt - 1'b1;
		end else begin
			unique case (state)
				ST_INIT_WAIT: next_state = ST_INIT_PRE;
				ST_INIT_PRE, ST_PRE: begin
					next_cmd   = CMD_PRE;
					next_addr  = MEM_A_BITS'(1) << AP_BIT;
					next_wait  = wait_of(T_RP_CYCLES);
					next_state = (state == ST_PRE) ? ST_DONE : ST_INIT_REF;
				end
				ST_INIT_REF: begin
					next_cmd   = CMD_REF;
					next_wait  = wait_of(RFC_CYCLES);
					next_refs  = init_refs - 2'h1;
					next_state = (init_refs == 2'h1) ? ST_INIT_MRS : ST_INIT_REF;
				end
				ST_INIT_MRS: begin
					next_cmd   = CMD_MRS;
					next_addr  = MODE_WORD;
					next_ba    = '0;
					next_wait  = wait_of(T_MRD_CYCLES);
					next_state = ST_IDLE;
				end
				ST_IDLE: begin
					if (ref_due) begin
						next_cmd   = CMD_PRE;
						next_addr  = MEM_A_BITS'(1) << AP_BIT;
						next_wait  = wait_of(T_RP_CYCLES);
						next_state = ST_REF;
					end else if (req_new) begin
						next_cmd   = CMD_ACT;
						next_addr  = MEM_A_BITS'(row);
						next_ba    = bank;
						next_wait  = wait_of(T_RCD_CYCLES);
						next_state = ST_RW;
					end
				end
				ST_RW: begin
					next_cmd   = lk_write ? CMD_WRITE : CMD_READ;
					next_addr  = MEM_A_BITS'(col);
					next_wait  = lk_write ? wait_of(BURST_LEN / 2 + 1 + WR_CYCLES)
					                      : wait_of(BURST_LEN / 2);
					next_state = ST_PRE;
				end
				ST_DONE: begin
					if (beat_cnt == '0) begin
						next_state = ST_IDLE;
					end
				end
				ST_REF: begin
					next_cmd   = CMD_REF;
					next_wait  = wait_of(RFC_CYCLES);
					next_state = ST_IDLE;
				end
				default: next_state = ST_IDLE;
			endcase
		end
	end

	// Complementary clock pair comes from two flops, so the two edges never skew by logic.
	always_ff @(posedge link_clk or posedge reset) begin
		if (reset) begin
			mem_clk_p <= 1'b0;
			mem_clk_n <= 1'b1;
			mem_cke   <= 1'b0;
		end else begin
			mem_clk_p <= ~mem_clk_p;
			mem_clk_n <= mem_clk_p;
			mem_cke   <= 1'b1;
		end
	end

	// Commands change on the falling memory clock edge and are sampled on the next rise.
	always_ff @(posedge link_clk or posedge reset) begin
		if (reset) begin
			state     <= ST_INIT_WAIT;
			wait_cnt  <= WAIT_BITS'(INIT_WAIT_CYCLES);
			init_refs <= 2'(INIT_REFRESHES);
			{mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= CMD_DESEL;
			mem_addr  <= '0;
			mem_ba    <= '0;
		end else if (slot) begin
			state     <= next_state;
			wait_cnt  <= next_wait;
			init_refs <= next_refs;
			{mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= next_cmd;
			mem_addr  <= next_addr;
			mem_ba    <= next_ba;
		end
	end

	always_ff @(posedge link_clk or posedge reset) begin
		if (reset) begin
			ref_timer <= '0;
			ref_due   <= 1'b0;
			init_flag <= 1'b0;
			req_seen  <= 1'b0;
			ack_tgl   <= 1'b0;
			lk_write  <= 1'b0;
			lk_wdata  <= '0;
			lk_wmask  <= '0;
		end else begin
			if (slot) begin
				ref_timer <= (ref_timer == '0) ? wait_of(REF_CYCLES) : ref_timer - 1'b1;
			end
			ref_due <= ref_hit | (ref_due & ~issue_ref);
			if (slot & (state == ST_INIT_MRS) & (wait_cnt == '0)) begin
				init_flag <= 1'b1;
			end
			if (issue_act) begin
				req_seen <= req_s;
				lk_write <= hold_write;
				lk_wdata <= hold_wdata;
				lk_wmask <= hold_wmask;
			end
			if (finish) begin
				ack_tgl <= ~ack_tgl;
			end
		end
	end

	// Strobes go out edge aligned with data; the board must add the quarter clock shift.
	always_ff @(posedge link_clk or posedge reset) begin
		if (reset) begin
			beat_cnt              <= '0;
			mem_dq_out            <= '0;
			mem_dq_oe_n           <= 1'b1;
			low_byte_strobe_out   <= 1'b0;
			low_byte_strobe_oe_n  <= 1'b1;
			high_byte_strobe_out  <= 1'b0;
			high_byte_strobe_oe_n <= 1'b1;
			low_byte_write_mask   <= 1'b0;
			high_byte_write_mask  <= 1'b0;
			for (int i = 0; i < BURST_LEN; i++) begin
				rd_buf[i] <= '0;
			end
		end else begin
			if (issue_rw) begin
				beat_cnt <= 4'h1;
			end else if (beat_cnt != '0) begin
				beat_cnt <= (beat_cnt == BEAT_END) ? 4'h0 : beat_cnt + 4'h1;
			end
			mem_dq_out            <= lk_wdata[wr_idx * DATA_BITS +: DATA_BITS];
			mem_dq_oe_n           <= ~dq_drive;
			low_byte_strobe_oe_n  <= ~dqs_drive;
			high_byte_strobe_oe_n <= ~dqs_drive;
			low_byte_strobe_out   <= dq_drive & ~wr_idx[0];
			high_byte_strobe_out  <= dq_drive & ~wr_idx[0];
			low_byte_write_mask   <= dq_drive & lk_wmask[2 * wr_idx];
			high_byte_write_mask  <= dq_drive & lk_wmask[2 * wr_idx + 1];
			if (rd_take) begin
				rd_buf[rd_idx] <= dq_s;
			end
		end
	end

	// Helper: link cycles since the last refresh, saturating.
	logic [WAIT_BITS-1:0] since_ref;
	always_ff @(posedge link_clk or posedge reset) begin
		if (reset) begin
			since_ref <= '0;
		end else if ((out_cmd == CMD_REF) | ~init_flag) begin
			since_ref <= '0;
		end else if (since_ref != '1) begin
			since_ref <= since_ref + 1'b1;
		end
	end

	chk_clock_pair: assert property (@(posedge link_clk) disable iff (reset)
		mem_clk_p != mem_clk_n) else $error("memory clock pair not complementary");
	chk_act_to_access: assert property (@(posedge link_clk) disable iff (reset)
		(out_cmd == CMD_ACT && !mem_clk_p) |-> ##6 (out_cmd == CMD_READ || out_cmd == CMD_WRITE))
		else $error("access did not follow activate after three clocks");
	chk_precharge_quiet: assert property (@(posedge link_clk) disable iff (reset)
		(out_cmd == CMD_PRE && !mem_clk_p) |-> ##2 (out_cmd == CMD_NOP)[*4])
		else $error("command issued inside precharge period");
	chk_mode_word: assert property (@(posedge link_clk) disable iff (reset)
		(out_cmd == CMD_MRS) |-> (mem_ba == '0 && mem_addr == MODE_WORD))
		else $error("mode register write other than burst four, latency three");
	chk_ref_after_pre: assert property (@(posedge link_clk) disable iff (reset)
		(out_cmd == CMD_REF && !mem_clk_p && init_flag) |-> $past(out_cmd, 6) == CMD_PRE)
		else $error("refresh not preceded by precharge all");
	chk_init_first: assert property (@(posedge link_clk) disable iff (reset)
		(out_cmd == CMD_ACT) |-> init_flag) else $error("activate before initialisation");
	chk_row_range: assert property (@(posedge link_clk) disable iff (reset)
		(out_cmd == CMD_ACT) |-> mem_addr[MEM_A_BITS-1] == 1'b0)
		else $error("row address outside 128 Mb range");
	chk_write_strobe: assert property (@(posedge link_clk) disable iff (reset)
		(out_cmd == CMD_WRITE && !mem_clk_p) |-> ##2 (!low_byte_strobe_oe_n && !low_byte_strobe_out
		&& !high_byte_strobe_oe_n) ##1 (low_byte_strobe_out && high_byte_strobe_out))
		else $error("write strobe preamble or first edge misplaced");
	chk_burst_four: assert property (@(posedge link_clk) disable iff (reset)
		$fell(mem_dq_oe_n) |-> ##1 (!mem_dq_oe_n)[*3] ##1 mem_dq_oe_n)
		else $error("write burst not four beats");
	chk_refresh_gap: assert property (@(posedge link_clk) disable iff (reset)
		since_ref <= WAIT_BITS'(2 * (REF_CYCLES + REF_SLACK_CYCLES)))
		else $error("refresh interval exceeded");
endmodule

// *** test/lpdm_mem_model.sv ***
// Behavioural x16 low power DDR memory that checks the command stream it is given.
`timescale 1ns/100ps
module lpdm_mem_model
	import lpdm_pkg::*;
#(
	parameter int INIT_WAIT = 20
) (
	input  wire logic                  link_clk,
	input  wire logic                  reset,
	input  wire logic                  clk_p,
	input  wire logic                  clk_n,
	input  wire logic [3:0]            cmd,
	input  wire logic [MEM_A_BITS-1:0] addr,
	input  wire logic [BANK_BITS-1:0]  ba,
	input  wire logic [DATA_BITS-1:0]  dq,
	input  wire logic [2:0]            oe_n,
	input  wire logic [1:0]            strobe,
	input  wire logic [1:0]            mask,
	output logic      [DATA_BITS-1:0]  dq_drive,
	output logic                       strobe_drive,
	output logic      [7:0]            fault_count,
	output logic      [15:0]           ref_count
);
	// Four equal banks of sixteen-bit words, kept only where written.
	logic [DATA_BITS-1:0] store [logic [WORD_ADDR_BITS-1:0]];
	logic [ROW_BITS-1:0]  open_row [4];
	logic [3:0]           open_bank;
	logic [COL_BITS-1:0]  col;
	logic [BANK_BITS-1:0] cur_ba;
	logic [1:0]           k;
	logic [DATA_BITS-1:0] w;
	logic                 mode_ok;
	int                   mclk, rd_t, wr_t, ready_at, ref_at;
	int                   act_at [4];

	function automatic logic [WORD_ADDR_BITS-1:0] key(input logic [1:0] beat);
		return {open_row[cur_ba], cur_ba, col[COL_BITS-1:2], beat};
	endfunction

	task automatic fault(input string m);
		fault_count = fault_count + 8'h01;
		$display("MISMATCH at %0t: memory saw %s", $time, m);
	endtask

	initial begin
		fault_count = 8'h00;
		ref_count = 16'h0000;
		dq_drive = 16'h0000;
		strobe_drive = 1'b0;
	end

	// Any clock period is accepted; the speed rating is the board's concern.
	always @(posedge link_clk or posedge reset) begin
		if (reset) begin
			mode_ok = 1'b0;
			open_bank = 4'h0;
			mclk = 0;
			rd_t = -1;
			wr_t = -1;
			ready_at = 0;
		end else begin
			if (clk_n !== ~clk_p) fault("clock pair not complementary");
			rd_t = (rd_t >= 0) ? rd_t + 1 : rd_t;
			wr_t = (wr_t >= 0) ? wr_t + 1 : wr_t;
			// A released bus keeps changing, so a stale value is never taken as data.
			dq_drive <= (rd_t >= 6) ? store[key(2'(rd_t - 6))] : ~dq_drive;
			strobe_drive <= ~strobe_drive;
			rd_t = (rd_t == 9) ? -1 : rd_t;
			if (wr_t >= 3) begin
				k = 2'(wr_t - 3);
				if (oe_n !== 3'h0 || strobe !== {2{~k[0]}}) fault("bad write lanes");
				w = store.exists(key(k)) ? store[key(k)] : 16'h0000;
				w[7:0] = mask[0] ? w[7:0] : dq[7:0];
				w[15:8] = mask[1] ? w[15:8] : dq[15:8];
				store[key(k)] = w;
				wr_t = (wr_t == 6) ? -1 : wr_t;
			end
			if (clk_p === 1'b0) begin
				mclk = mclk + 1;
				if (cmd != CMD_NOP && cmd != CMD_DESEL && (mclk < ready_at || mclk < INIT_WAIT))
					fault("command too early");
				case (cmd)
					CMD_ACT: begin
						if (addr[MEM_A_BITS-1] !== 1'b0) fault("upper row bit high");
						open_row[ba] = addr[ROW_BITS-1:0];
						open_bank[ba] = 1'b1;
						act_at[ba] = mclk;
					end
					CMD_READ, CMD_WRITE: begin
						if (!mode_ok || !open_bank[ba]) fault("access before setup");
						if (mclk - act_at[ba] < T_RCD_CYCLES) fault("short tRCD");
						cur_ba = ba;
						col = addr[COL_BITS-1:0];
						if (cmd == CMD_READ) rd_t = 0;
						else wr_t = 0;
					end
					CMD_PRE: begin
						if (addr[AP_BIT]) open_bank = 4'h0;
						else open_bank[ba] = 1'b0;
						ready_at = mclk + T_RP_CYCLES;
					end
					CMD_REF: begin
						if (open_bank != 4'h0) fault("refresh with bank open");
						if (mode_ok && mclk - ref_at > REF_CYCLES + REF_SLACK_CYCLES)
							fault("refresh gap too long");
						ref_at = mclk;
						ref_count = ref_count + 16'h0001;
						ready_at = mclk + RFC_CYCLES;
					end
					CMD_MRS: begin
						if (ba != 2'h0 || addr != 13'h032) fault("bad mode word");
						mode_ok = 1'b1;
						ready_at = mclk + T_MRD_CYCLES;
					end
					default: begin
					end
				endcase
			end
		end
	end
endmodule

// *** test/test_lpdm_ctrl.sv ***
// Self-checking bench for the pattern store controller against a behavioural memory.
`timescale 1ns/100ps
module test_lpdm_ctrl
	import lpdm_pkg::*;
;
	localparam int INIT_WAIT  = 20;
	localparam int MAX_CYCLES = 40000;
	typedef struct {
		logic                      wr;
		logic [WORD_ADDR_BITS-1:0] addr;
		logic [LINE_BITS-1:0]      wdata;
		logic [MASK_BITS-1:0]      wmask;
		logic [LINE_BITS-1:0]      exp;
	} lpdm_row_type;
	logic                      clk, reset, link_clk, req_valid, req_write, req_ready, rsp_valid;
	logic                      init_done, clk_p, clk_n, cke, cs_n, ras_n, cas_n, we_n, dq_oe_n;
	logic                      ls_out, ls_oe_n, hs_out, hs_oe_n, lmask, hmask, strobe_drive;
	logic [WORD_ADDR_BITS-1:0] req_addr;
	logic [LINE_BITS-1:0]      req_wdata, rsp_rdata, rd;
	logic [MASK_BITS-1:0]      req_wmask;
	logic [MEM_A_BITS-1:0]     mem_addr;
	logic [BANK_BITS-1:0]      mem_ba;
	logic [DATA_BITS-1:0]      dq_out, dq_drive;
	logic [7:0]                fault_count;
	logic [15:0]               ref_count;
	wire logic [DATA_BITS-1:0] dq_wire = (dq_oe_n === 1'b0) ? dq_out : dq_drive;
	wire logic                 ls_wire = (ls_oe_n === 1'b0) ? ls_out : strobe_drive;
	wire logic                 hs_wire = (hs_oe_n === 1'b0) ? hs_out : ~strobe_drive;
	int                        err_total, checks, cycles, r0;
	lpdm_row_type              rows [10];

	lpdm_ctrl #(.INIT_WAIT_CYCLES(INIT_WAIT)) lpdm_ctrl_i (
		.clk(clk), .reset(reset), .link_clk(link_clk), .req_valid(req_valid),
		.req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
		.req_wdata(req_wdata), .req_wmask(req_wmask), .rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata), .init_done(init_done), .mem_clk_p(clk_p), .mem_clk_n(clk_n),
		.mem_cke(cke), .mem_cs_n(cs_n), .mem_ras_n(ras_n), .mem_cas_n(cas_n), .mem_we_n(we_n),
		.mem_addr(mem_addr), .mem_ba(mem_ba), .mem_dq_in(dq_wire), .mem_dq_out(dq_out),
		.mem_dq_oe_n(dq_oe_n), .low_byte_strobe_in(ls_wire), .low_byte_strobe_out(ls_out),
		.low_byte_strobe_oe_n(ls_oe_n), .high_byte_strobe_in(hs_wire),
		.high_byte_strobe_out(hs_out), .high_byte_strobe_oe_n(hs_oe_n),
		.low_byte_write_mask(lmask), .high_byte_write_mask(hmask));

	lpdm_mem_model #(.INIT_WAIT(INIT_WAIT)) lpdm_mem_model_i (
		.link_clk(link_clk), .reset(reset), .clk_p(clk_p), .clk_n(clk_n),
		.cmd({cs_n, ras_n, cas_n, we_n}), .addr(mem_addr), .ba(mem_ba), .dq(dq_wire),
		.oe_n({dq_oe_n, ls_oe_n, hs_oe_n}), .strobe({hs_out, ls_out}), .mask({hmask, lmask}),
		.dq_drive(dq_drive), .strobe_drive(strobe_drive), .fault_count(fault_count),
		.ref_count(ref_count));

	task automatic check(input logic [LINE_BITS-1:0] seen, input logic [LINE_BITS-1:0] exp,
			input string what);
		checks = checks + 1;
		if (seen !== exp) begin
			err_total = err_total + 1;
			$display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic wait_init();
		int n;
		n = 0;
		while (init_done !== 1'b1 && n < 3000) begin
			@(posedge clk);
			check(req_ready & ~init_done, 1'b0, "ready before setup");
			n = n + 1;
		end
		#1;
		check(init_done, 1'b1, "setup finished");
		check(cke, 1'b1, "clock enable after setup");
	endtask

	// The request is held until the edge that takes it, then the answer is awaited.
	task automatic access(input lpdm_row_type r, output logic [LINE_BITS-1:0] data);
		int n;
		n = 0;
		req_valid = 1'b1;
		req_write = r.wr;
		req_addr = r.addr;
		req_wdata = r.wdata;
		req_wmask = r.wmask;
		do begin
			@(posedge clk);
			n = n + 1;
		end while (req_ready !== 1'b1 && n < 200);
		#1;
		req_valid = 1'b0;
		do begin
			@(posedge clk);
			n = n + 1;
		end while (rsp_valid !== 1'b1 && n < 500);
		data = rsp_rdata;
		#1;
		check(n < 500, 1'b1, "request answered");
	endtask

	always #5 clk = ~clk;

	initial begin
		link_clk = 1'b0;
		#3.3;
		forever #7.5 link_clk = ~link_clk;
	end

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == MAX_CYCLES) begin
			err_total = err_total + 1;
			summarize();
		end
	end

	initial begin
		rows = '{
			'{1'b1, {12'h000, 2'h0, 9'h000}, 64'h0123_4567_89ab_cdef, 8'h00, 64'h0},
			'{1'b1, {12'h5a5, 2'h1, 9'h1fc}, 64'hfedc_ba98_7654_3210, 8'h00, 64'h0},
			'{1'b1, {12'hfff, 2'h2, 9'h004}, 64'h5a5a_a5a5_0ff0_f00f, 8'h00, 64'h0},
			'{1'b1, {12'h001, 2'h3, 9'h100}, 64'h1357_9bdf_2468_ace0, 8'h00, 64'h0},
			'{1'b0, {12'h000, 2'h0, 9'h000}, 64'h0, 8'h00, 64'h0123_4567_89ab_cdef},
			'{1'b0, {12'h5a5, 2'h1, 9'h1fc}, 64'h0, 8'h00, 64'hfedc_ba98_7654_3210},
			'{1'b0, {12'hfff, 2'h2, 9'h004}, 64'h0, 8'h00, 64'h5a5a_a5a5_0ff0_f00f},
			'{1'b0, {12'h001, 2'h3, 9'h100}, 64'h0, 8'h00, 64'h1357_9bdf_2468_ace0},
			'{1'b1, {12'h000, 2'h0, 9'h000}, 64'hffff_ffff_ffff_ffff, 8'h96, 64'h0},
			'{1'b0, {12'h000, 2'h0, 9'h000}, 64'h0, 8'h00, 64'h01ff_ff67_ffab_cdff}};
		clk = 1'b0;
		reset = 1'b1;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_addr = '0;
		req_wdata = '0;
		req_wmask = '0;
		err_total = 0;
		checks = 0;
		cycles = 0;
		repeat (3) @(posedge clk);
		#1;
		check({cke, cs_n, ras_n, cas_n, we_n}, {1'b0, CMD_DESEL}, "command in reset");
		check({dq_oe_n, ls_oe_n, hs_oe_n, init_done}, 4'he, "lanes in reset");
		reset = 1'b0;
		wait_init();
		$display("Test reset done");
		for (int i = 0; i < 10; i++) begin
			access(rows[i], rd);
			if (!rows[i].wr) check(rd, rows[i].exp, "read data");
			$display("Test row %0d done", i);
		end
		r0 = ref_count;
		repeat (2 * (REF_CYCLES + REF_SLACK_CYCLES) * 3) @(posedge clk);
		#1;
		check(ref_count >= r0 + 2, 1'b1, "idle refreshes");
		$display("Test refresh done");
		reset = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		check({init_done, req_ready}, 2'h0, "ready in second reset");
		reset = 1'b0;
		wait_init();
		access(rows[6], rd);
		check(rd, rows[6].exp, "read after second reset");
		$display("Test second reset done");
		check(fault_count, 8'h00, "memory faults");
		summarize();
	end
endmodule
